// file: rtl/irs_root_setup.sv
// post bus reset root and cycle master setup for the resource manager node
`timescale 1ns/1ps
`include "irs_map.svh"

module irs_root_setup #(
   parameter int unsigned CM_DEADLINE_CYC = `IRS_CM_DEADLINE_CYC,
   parameter int unsigned CS_WAIT_CYC     = `IRS_CS_WAIT_CYC
) (
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                bus_reset_done,
   input  wire logic [5:0]          self_id,
   input  wire logic [5:0]          root_id,
   input  wire logic [5:0]          rm_id,
   input  wire logic                bm_present,
   input  wire logic                bc_capable,
   input  wire logic                cs_seen,
   input  wire logic                bc_write_valid,
   input  wire logic                rm_unchanged_ok,
   input  wire logic                cand_valid,
   input  wire logic [5:0]          cand_id,
   input  wire irs_pkg::irs_rsp_s   rsp,
   input  wire logic                req_ready,
   input  wire logic                phy_ready,
   output irs_pkg::irs_req_s        req,
   output irs_pkg::irs_phycfg_s     phy_cfg,
   output logic                     bus_reset_req,
   output logic                     cm_late,
   output logic                     busy
);
   import irs_pkg::*;

   // far side register targets carried in req and rsp
   localparam logic [1:0] TGT_BIB = 2'h0;
   localparam logic [1:0] TGT_CLR = 2'h1;
   localparam logic [1:0] TGT_BC  = 2'h2;
   localparam logic [1:0] TGT_GEN = 2'h3;

   irs_state_s s;
   irs_state_s next_s;
   logic       lost_root;
   logic       check_rm;
   logic       evidence;

   function automatic irs_req_s mk_req(input logic rd, input logic [5:0] n, input logic [1:0] t,
                                       input logic [31:0] d);
      irs_req_s r;
      r.valid   = 1'b1;
      r.is_read = rd;
      r.node    = n;
      r.target  = t;
      r.data    = d;
      return r;
   endfunction : mk_req

   function automatic irs_phycfg_s mk_phy(input logic [5:0] n);
      irs_phycfg_s p;
      p.valid      = 1'b1;
      p.phy_id     = n;
      p.force_root = 1'b1;
      return p;
   endfunction : mk_phy

   function automatic logic is_active(input irs_state_e st);
      return (st != IRS_IDLE) && (st != IRS_DONE);
   endfunction : is_active

   function automatic logic rsp_hit(input irs_rsp_s r, input logic [1:0] t);
      return r.valid && (r.target == t);
   endfunction : rsp_hit

   // self is the fallback when no other cycle master capable node is known
   function automatic logic [5:0] pick_cand(input logic v, input logic [5:0] c, input logic [5:0] own);
      return v ? c : own;
   endfunction : pick_cand

   // lost root: manager here, root elsewhere, nobody managing the bus
   assign lost_root = (rm_id == self_id) && (root_id != self_id) && !bm_present;
   assign check_rm  = (rm_id != self_id) && bc_capable;
   // pulses count in the very cycle they arrive, a run restart included
   assign evidence  = bc_write_valid || rm_unchanged_ok;

   always_comb begin
      next_s = s;
      next_s.bus_reset = 1'b0;
      if (s.req.valid && req_ready) begin
         next_s.req.valid = 1'b0;
      end
      if (s.phy.valid && phy_ready) begin
         next_s.phy.valid = 1'b0;
      end
      // counter parks at the limit so cm_late stays up until the next run
      if (is_active(s.st)) begin
         if (s.tmr == 13'(CM_DEADLINE_CYC)) begin
            next_s.cm_late = 1'b1;
         end else begin
            next_s.tmr = s.tmr + 13'h1;
         end
      end
      if (evidence) begin
         next_s.rm_ok = 1'b1;
      end
      unique case (s.st)
         IRS_IDLE, IRS_DONE: begin
            if (bus_reset_done) begin
               next_s.st      = IRS_CHECK;
               next_s.tmr     = 13'h0;
               next_s.cs_tmr  = 13'h0;
               next_s.cm_late = 1'b0;
               next_s.rm_ok   = evidence;
            end
         end
         IRS_CHECK: begin
            // no wait for a bus manager election here
            if (lost_root) begin
               next_s.st = IRS_WAITCS;
            end else if (check_rm) begin
               next_s.st = IRS_CAPCHK;
               next_s.req = mk_req(1'b1, rm_id, TGT_BC, 32'h0);
            end else begin
               next_s.st = IRS_DONE;
            end
         end
         IRS_WAITCS: begin
            // short wait only; cycle starts skip the read
            if (cs_seen) begin
               next_s.st = IRS_PHYCFG;
            end else if (s.cs_tmr == 13'(CS_WAIT_CYC)) begin
               next_s.st  = IRS_RDBIB;
               next_s.req = mk_req(1'b1, root_id, TGT_BIB, 32'h0);
            end else begin
               next_s.cs_tmr = s.cs_tmr + 13'h1;
            end
         end
         IRS_RDBIB: begin
            if (rsp_hit(rsp, TGT_BIB)) begin
               if (rsp.ok && rsp.data[`IRS_CMSTR_BIT]) begin
                  next_s.st = IRS_PHYCFG;
               end else begin
                  next_s.st   = IRS_FORCE;
                  next_s.cand = pick_cand(cand_valid, cand_id, self_id);
               end
            end else if (s.cm_late) begin
               // silent root: deadline already gone, so move the root role anyway
               next_s.st   = IRS_FORCE;
               next_s.cand = pick_cand(cand_valid, cand_id, self_id);
            end
         end
         // both packets leave together; done waits until both are taken
         IRS_PHYCFG: begin
            if (!s.phy.valid && !s.req.valid) begin
               next_s.phy = mk_phy(root_id);
               next_s.req = mk_req(1'b0, root_id, TGT_CLR, 32'(1) << `IRS_CMSTR_BIT);
               next_s.st  = IRS_WRCLR;
            end
         end
         IRS_WRCLR: begin
            if (!s.req.valid && !s.phy.valid) begin
               next_s.st = IRS_DONE;
            end
         end
         IRS_FORCE: begin
            if (!s.phy.valid) begin
               next_s.phy = mk_phy(s.cand);
               next_s.st  = IRS_RESET;
            end
         end
         IRS_RESET: begin
            if (!s.phy.valid) begin
               next_s.bus_reset = 1'b1;
               next_s.st        = IRS_DONE;
            end
         end
         IRS_CAPCHK: begin
            if (s.rm_ok) begin
               next_s.st = IRS_DONE;
            end else if (rsp_hit(rsp, TGT_BC)) begin
               if (rsp.ok && rsp.data[`IRS_BC_VALID_BIT]) begin
                  next_s.st = IRS_DONE;
               end else begin
                  next_s.req = mk_req(1'b1, rm_id, TGT_GEN, 32'h0);
               end
            end else if (rsp_hit(rsp, TGT_GEN)) begin
               next_s.st = (rsp.ok && rsp.data != 32'h0) ? IRS_DONE : IRS_TAKE;
            end else if (s.cm_late) begin
               // no answer from the manager is no proof of capability
               next_s.st = IRS_TAKE;
            end
         end
         IRS_TAKE: begin
            next_s.cand = self_id;
            next_s.st   = IRS_FORCE;
         end
         default: begin
            next_s.st = IRS_IDLE;
         end
      endcase
   end

   // one register for all state, so reset clears every field together
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign req           = s.req;
   assign phy_cfg       = s.phy;
   assign bus_reset_req = s.bus_reset;
   assign cm_late       = s.cm_late;
   assign busy          = is_active(s.st);
endmodule : irs_root_setup

// file: common/irs_map.svh
// timing counts and field constants for the resource manager root setup block
`ifndef IRS_MAP_SVH
`define IRS_MAP_SVH
`define IRS_CLK_HZ          20000000
`define IRS_CM_DEADLINE_NS  125000
`define IRS_CM_DEADLINE_CYC ((`IRS_CM_DEADLINE_NS / 50))
`define IRS_CS_WAIT_NS      20000
`define IRS_CS_WAIT_CYC     ((`IRS_CS_WAIT_NS / 50))
`define IRS_BCAST_CH        6'h1f
`define IRS_BC_VALID_BIT    31
`define IRS_CMSTR_BIT       8
`endif

// file: common/irs_pkg.sv
// types for the resource manager root setup block
package irs_pkg;
   typedef enum logic [3:0] {
      IRS_IDLE   = 4'h0,
      IRS_CHECK  = 4'h1,
      IRS_WAITCS = 4'h3,
      IRS_RDBIB  = 4'h2,
      IRS_PHYCFG = 4'h6,
      IRS_WRCLR  = 4'h7,
      IRS_FORCE  = 4'h5,
      IRS_RESET  = 4'h4,
      IRS_CAPCHK = 4'hc,
      IRS_TAKE   = 4'hd,
      IRS_DONE   = 4'hf
   } irs_state_e;

   typedef struct packed {
      logic       valid;
      logic [5:0] phy_id;
      logic       force_root;
   } irs_phycfg_s;

   typedef struct packed {
      logic        valid;
      logic        is_read;
      logic [5:0]  node;
      logic [1:0]  target;
      logic [31:0] data;
   } irs_req_s;

   typedef struct packed {
      logic        valid;
      logic        ok;
      logic [1:0]  target;
      logic [31:0] data;
   } irs_rsp_s;

   typedef struct packed {
      irs_state_e  st;
      logic [12:0] tmr;
      logic [12:0] cs_tmr;
      logic [5:0]  cand;
      logic        rm_ok;
      irs_phycfg_s phy;
      irs_req_s    req;
      logic        bus_reset;
      logic        cm_late;
   } irs_state_s;
endpackage : irs_pkg

// file: tb/irs_root_setup_monitor.sv
// port assertions for the root setup block
`timescale 1ns/1ps
module irs_root_setup_monitor import irs_pkg::*; (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        bus_reset_done,
   input wire logic [5:0]  self_id,
   input wire logic [5:0]  root_id,
   input wire logic [5:0]  rm_id,
   input wire logic        bm_present,
   input wire logic        bc_capable,
   input wire logic        bc_write_valid,
   input wire logic        rm_unchanged_ok,
   input wire logic        cand_valid,
   input wire logic [5:0]  cand_id,
   input wire logic        req_ready,
   input wire logic        phy_ready,
   input wire irs_req_s    req,
   input wire irs_phycfg_s phy_cfg,
   input wire logic        bus_reset_req,
   input wire logic        cm_late,
   input wire logic        busy
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence go_s; bus_reset_done && !busy; endsequence
   sequence lost_s; rm_id == self_id && root_id != self_id && !bm_present; endsequence
   sequence ask_s; rm_id != self_id && bc_capable && !bc_write_valid && !rm_unchanged_ok; endsequence
   a_req_hold: assert property (req.valid && !req_ready |=> req.valid && $stable(req)) else $error("req dropped");
   a_phy_hold: assert property (phy_cfg.valid && !phy_ready |=> $stable(phy_cfg)) else $error("cfg dropped");
   a_force_flag: assert property (phy_cfg.valid |-> phy_cfg.force_root && (phy_cfg.phy_id == root_id ||
      phy_cfg.phy_id == self_id || (cand_valid && phy_cfg.phy_id == cand_id))) else $error("bad force target");
   a_clr_write: assert property (req.valid && !req.is_read && req.target == 2'h1 |->
      req.data[8] && req.node == root_id) else $error("bad clear");
   a_rst_pulse: assert property (bus_reset_req |=> !bus_reset_req) else $error("long reset");
   a_start_busy: assert property (go_s |-> ##[1:2] busy) else $error("no start");
   a_late_cause: assert property ($rose(cm_late) |-> $past(busy)) else $error("late idle");
   a_cs_wait: assert property (go_s ##0 lost_s |-> ##[1:420] (req.valid || phy_cfg.valid)) else $error("slow");
   a_cap_read: assert property (go_s ##0 ask_s |-> ##[1:3] (req.valid && req.is_read && req.target == 2'h2
      && req.node == rm_id)) else $error("no cap read");
endmodule : irs_root_setup_monitor
bind irs_root_setup irs_root_setup_monitor mon (.*);

// file: tb/irs_far_node.sv
// model of the far bus nodes
`timescale 1ns/1ps
module irs_far_node import irs_pkg::*; (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [3:0]  cfg,
   input wire logic        mute,
   input wire irs_req_s    req,
   input wire irs_phycfg_s phy_cfg,
   output logic            req_ready,
   output logic            phy_ready,
   output irs_rsp_s        rsp
);
   logic stall;
   // cfg: slow, root cmstr capable, manager msb, generation; mute never accepts a request, phy configs are still taken
   assign req_ready = req.valid && !(cfg[3] && stall) && !mute;
   assign phy_ready = phy_cfg.valid;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stall <= 1'b1;
         rsp <= '0;
      end else begin
         stall <= !stall;
         rsp.valid <= req_ready && req.is_read;
         rsp.ok <= 1'b1;
         rsp.target <= req.target;
         // idle data toggles so stale data never looks valid
         rsp.data <= ~rsp.data;
         if (req_ready && req.is_read) begin
            if (req.target == 2'h0) begin
               rsp.data <= {23'h0, cfg[2], 8'h0};
            end else if (req.target == 2'h2) begin
               rsp.data <= {cfg[1], 31'h0};
            end else begin
               rsp.data <= {31'h0, cfg[0]};
            end
         end
      end
   end
endmodule : irs_far_node

// file: tb/test_irs_root_setup.sv
// bench for the root setup block
`timescale 1ns/1ps
module test_irs_root_setup;
   import irs_pkg::*;
   logic        clk, rst_b, bus_reset_done, bm_present, bc_capable, cs_seen, bc_write_valid, mute;
   logic        rm_unchanged_ok, cand_valid, req_ready, phy_ready, bus_reset_req, cm_late, busy;
   logic [5:0]  self_id, root_id, rm_id, cand_id;
   logic [3:0]  cfg;
   irs_rsp_s    rsp;
   irs_req_s    req;
   irs_phycfg_s phy_cfg;
   int          n_fail = 0;
   int          comparisons = 0;
   irs_root_setup #(.CM_DEADLINE_CYC(40), .CS_WAIT_CYC(8)) dut (.*);
   irs_far_node far (.*);
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_fail++;
         $display("FAIL %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic close_out;
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : close_out
   // one run; id 0 means no phy config
   task automatic run(input logic [5:0] xid, input logic xrst, input logic xwr, input logic xlate);
      logic [6:0] pc = '0;
      logic       rs = 1'b0;
      logic       wr = 1'b0;
      int         idle = 0;
      @(posedge clk);
      bus_reset_done <= 1'b1;
      @(posedge clk);
      bus_reset_done <= 1'b0;
      for (int k = 0; k < 300 && idle < 3; k++) begin
         @(negedge clk);
         idle = busy ? 0 : idle + 1;
         if (phy_cfg.valid) pc = {phy_cfg.force_root, phy_cfg.phy_id};
         rs |= bus_reset_req;
         wr |= req.valid && !req.is_read && req.target == 2'h1;
      end
      // judged at the falling edge, away from the edge that moves the outputs
      chk("phy", {25'h0, pc}, {25'h0, xid != 6'h0, xid});
      chk("reset", {31'h0, rs}, {31'h0, xrst});
      chk("write", {31'h0, wr}, {31'h0, xwr});
      chk("late", {31'h0, cm_late}, {31'h0, xlate});
      chk("idle", {31'h0, busy}, 32'h0);
      @(posedge clk);
   endtask : run
   task automatic t_cmstr;
      cs_seen <= 1'b1;
      run(6'h02, 1'b0, 1'b1, 1'b0);
      cs_seen <= 1'b0;
      cfg <= 4'hc;
      run(6'h02, 1'b0, 1'b1, 1'b0);
   endtask : t_cmstr
   task automatic t_force;
      cfg <= 4'h0;
      cand_valid <= 1'b1;
      run(6'h05, 1'b1, 1'b0, 1'b0);
      cand_valid <= 1'b0;
      run(6'h01, 1'b1, 1'b0, 1'b0);
   endtask : t_force
   task automatic t_cap;
      rm_id <= 6'h03;
      bc_capable <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         cfg <= {2'h0, i == 1, i == 2};
         bc_write_valid <= i == 3;
         rm_unchanged_ok <= i == 4;
         run(i == 0 ? 6'h01 : 6'h00, i == 0, 1'b0, 1'b0);
      end
   endtask : t_cap
   // root never answers its bus info read: deadline flag, then self forced root
   task automatic t_late;
      rm_id <= 6'h01;
      bc_capable <= 1'b0;
      rm_unchanged_ok <= 1'b0;
      cfg <= 4'h0;
      mute <= 1'b1;
      run(6'h01, 1'b1, 1'b0, 1'b1);
   endtask : t_late
   initial begin
      {bus_reset_done, bm_present, bc_capable, cs_seen, bc_write_valid, rm_unchanged_ok, cand_valid, mute} = '0;
      {self_id, root_id, rm_id, cand_id, cfg} = {6'h01, 6'h02, 6'h01, 6'h05, 4'h0};
      rst_b = 1'b0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      t_cmstr();
      t_force();
      t_cap();
      t_late();
      close_out();
   end
   initial begin
      #1000000;
      n_fail++;
      close_out();
   end
endmodule : test_irs_root_setup
